// ===== inc/poll_pkg.sv
`default_nettype none

package poll_pkg;

   // Slave address field widths and the address classes on the serial line.
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_BROADCAST = 8'h00;
   localparam logic [7:0] ADDR_UNICAST_MAX = 8'hf7;
   localparam logic [7:0] ADDR_RESERVED_MIN = 8'hf8;

   // Number of consecutive silent requests that forces diagnostic mode.
   localparam logic [1:0] MISS_LIMIT = 2'h3;

   // Diagnose packet layout: three bytes, the first holding the length.
   localparam logic [7:0] DIAG_LEN = 8'h03;
   localparam logic [1:0] DIAG_IDX_LEN = 2'h0;
   localparam logic [1:0] DIAG_IDX_PAGE = 2'h1;
   localparam logic [1:0] DIAG_IDX_MODULE = 2'h2;

   // Clock rate and the default response timeout and diagnose period.
   localparam int CLK_HZ = 25000000;
   localparam int TIMEOUT_MS = 1000;
   localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
   localparam int DIAG_PERIOD_MS = 1000;
   localparam int DIAG_PERIOD_CYC = CLK_HZ / 1000 * DIAG_PERIOD_MS;
   localparam int CNT_W = 32;

   // Master sequencer states.
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_SEND = 3'b001,
      ST_WAIT = 3'b010,
      ST_LEARN = 3'b011
   } seq_state_e;

endpackage : poll_pkg

`default_nettype wire

// ===== inc/diag_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries a diagnose packet request from the sequencer to the byte emitter.
interface diag_if;
   logic start;
   logic busy;
   logic [7:0] page;
   logic [7:0] module_num;

   modport seq
   (
      output start,
      output page,
      output module_num,
      input busy
   );

   modport emit
   (
      input start,
      input page,
      input module_num,
      output busy
   );
endinterface : diag_if

`default_nettype wire

// ===== src/diag_emitter.sv
`timescale 1ns/10ps
`default_nettype none

// Emits the three-byte diagnose packet one byte per accepted transfer.
module diag_emitter
   import poll_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   diag_if.emit dg,
   output logic diagValid,
   input wire logic diagReady,
   output logic [7:0] diagByte,
   output logic diagLast
);

   // Byte index within the packet and the latched packet contents.
   logic [1:0] idx_ff;
   logic busy_ff;
   logic [7:0] page_ff;
   logic [7:0] module_ff;

   assign dg.busy = busy_ff;
   assign diagValid = busy_ff;
   assign diagLast = busy_ff && (idx_ff == DIAG_IDX_MODULE);

   // Latch page and module at start so the packet stays coherent.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         busy_ff <= 1'b0;
         idx_ff <= DIAG_IDX_LEN;
         page_ff <= 8'h00;
         module_ff <= 8'h00;
      end
      else if (!busy_ff && dg.start)
      begin
         busy_ff <= 1'b1;
         idx_ff <= DIAG_IDX_LEN;
         page_ff <= dg.page;
         module_ff <= dg.module_num;
      end
      else if (busy_ff && diagReady)
      begin
         // The last byte ends the packet.
         if (idx_ff == DIAG_IDX_MODULE)
         begin
            busy_ff <= 1'b0;
         end
         idx_ff <= idx_ff + 2'h1;
      end
   end

   // Byte order is length, page, module number.
   always_comb
   begin
      case (idx_ff)
         DIAG_IDX_LEN: diagByte = DIAG_LEN;
         DIAG_IDX_PAGE: diagByte = page_ff;
         DIAG_IDX_MODULE: diagByte = module_ff;
         default: diagByte = 8'h00;
      endcase
   end

   // The first byte emitted after an accepted start is the length.
   property p_diag_len_first;
      @(posedge mclk) disable iff (rst)
      (!busy_ff && dg.start) |=> (diagByte == DIAG_LEN);
   endproperty
   a_diag_len_first: assert property (p_diag_len_first)
      else $error("Diagnose packet does not open with its length.");

endmodule : diag_emitter

`default_nettype wire

// ===== src/modbus_serial_poll_diag.sv
// Operation
// - Address 0 broadcast, 1-247 slaves, rest reserved.
// - Every request carries the target slave address.
// - Only one request outstanding at a time.
// - Broadcast gets no reply; master never waits.
// - Slaves answer unsupported or bad requests with exceptions.
// - Abandon a request after the response timeout.
// - Three silent requests in a row enter diagnostics.
// - Diagnostic mode sends diagnose packets periodically.
// - Any correct reply leaves diagnostic mode.
// - Diagnose packet: length, page, module number.
// - Learning mode listens as slave, master only.
// - Page number follows the page select scheme.
`timescale 1ns/10ps
`default_nettype none

module modbus_serial_poll_diag
   import poll_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int DIAG_PERIOD_CYCLES = DIAG_PERIOD_CYC
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic masterMode,
   input wire logic learnEnable,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic [poll_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [7:0] reqPage,
   input wire logic [7:0] reqModule,
   output logic txStart,
   output logic [poll_pkg::ADDR_W-1:0] txAddr,
   input wire logic txDone,
   input wire logic rxValid,
   input wire logic [poll_pkg::ADDR_W-1:0] rxAddr,
   input wire logic rxException,
   input wire logic rxCrcOk,
   output logic reqFailed,
   output logic reqOk,
   output logic exceptionSeen,
   output logic learnValid,
   output logic [poll_pkg::ADDR_W-1:0] learnAddr,
   output logic diagMode,
   output logic diagValid,
   input wire logic diagReady,
   output logic [7:0] diagByte,
   output logic diagLast
);

   // Sequencer state and the request held while it is outstanding.
   seq_state_e state_ff;
   seq_state_e nxt_state;
   logic [ADDR_W-1:0] addr_ff;
   logic [7:0] page_ff;
   logic [7:0] module_ff;
   logic [CNT_W-1:0] timer_ff;
   logic [CNT_W-1:0] period_ff;
   logic [1:0] miss_ff;
   logic diag_ff;
   logic txStart_ff;
   logic reqFailed_ff;
   logic reqOk_ff;
   logic exc_ff;
   logic learnValid_ff;
   logic [ADDR_W-1:0] learnAddr_ff;

   // Decoded conditions used by several processes.
   logic isBroadcast;
   logic isReserved;
   logic replyMatch;
   logic timedOut;
   logic learnActive;

   diag_if dg();

   // The held request is tested for broadcast, the offered one for reserved.
   assign isBroadcast = (addr_ff == ADDR_BROADCAST);
   assign isReserved = (reqAddr >= ADDR_RESERVED_MIN);
   // A reply counts only from the addressed slave, with good framing.
   assign replyMatch = (state_ff == ST_WAIT) && rxValid && rxCrcOk && (rxAddr == addr_ff);
   assign timedOut = (state_ff == ST_WAIT) && !replyMatch
                     && (timer_ff == CNT_W'(TIMEOUT_CYCLES - 1));
   // Learning is refused unless the gateway is configured as master.
   assign learnActive = learnEnable && masterMode;

   // A new request is accepted only when nothing is outstanding.
   assign reqReady = (state_ff == ST_IDLE) && masterMode && !learnEnable;

   assign txStart = txStart_ff;
   assign txAddr = addr_ff;
   assign reqFailed = reqFailed_ff;
   assign reqOk = reqOk_ff;
   assign exceptionSeen = exc_ff;
   assign learnValid = learnValid_ff;
   assign learnAddr = learnAddr_ff;
   assign diagMode = diag_ff;

   // Next-state logic of the request sequencer.
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (learnActive)
               nxt_state = ST_LEARN;
            else if (reqValid && reqReady && !isReserved)
               nxt_state = ST_SEND;
         ST_SEND:
         begin
            // Broadcasts return to idle without waiting for any reply.
            if (txDone)
               nxt_state = isBroadcast ? ST_IDLE : ST_WAIT;
         end
         ST_WAIT:
            if (replyMatch || timedOut)
               nxt_state = ST_IDLE;
         ST_LEARN:
            if (!learnActive)
               nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Capture the request; a reserved address is dropped as never assigned.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         addr_ff <= 8'h00;
         page_ff <= 8'h00;
         module_ff <= 8'h00;
         txStart_ff <= 1'b0;
      end
      else
      begin
         txStart_ff <= 1'b0;
         if (state_ff == ST_IDLE && reqValid && reqReady && !learnActive && !isReserved)
         begin
            addr_ff <= reqAddr;
            page_ff <= reqPage;
            module_ff <= reqModule;
            txStart_ff <= 1'b1;
         end
      end
   end

   // Response timer restarts when the frame finishes leaving the line.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         timer_ff <= '0;
      else if (state_ff == ST_SEND && txDone)
         timer_ff <= '0;
      else if (state_ff == ST_WAIT)
         timer_ff <= timer_ff + CNT_W'(1);
   end

   // One-cycle outcome pulses for the outside world.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         reqFailed_ff <= 1'b0;
         reqOk_ff <= 1'b0;
         exc_ff <= 1'b0;
      end
      else
      begin
         reqFailed_ff <= timedOut;
         reqOk_ff <= replyMatch;
         // An exception is still a reply, so it also clears the misses.
         exc_ff <= replyMatch && rxException;
      end
   end

   // Consecutive miss counter and the diagnostic mode flag.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         miss_ff <= 2'h0;
         diag_ff <= 1'b0;
      end
      else if (replyMatch)
      begin
         miss_ff <= 2'h0;
         diag_ff <= 1'b0;
      end
      else if (timedOut)
      begin
         if (miss_ff + 2'h1 == MISS_LIMIT)
            diag_ff <= 1'b1;
         if (miss_ff != MISS_LIMIT)
            miss_ff <= miss_ff + 2'h1;
      end
   end

   // Periodic diagnose trigger while diagnostics are active.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         period_ff <= '0;
      else if (!diag_ff || period_ff == CNT_W'(DIAG_PERIOD_CYCLES - 1))
         period_ff <= '0;
      else
         period_ff <= period_ff + CNT_W'(1);
   end

   // A packet is started at each period boundary; a busy emitter skips one.
   assign dg.start = diag_ff && (period_ff == '0);
   assign dg.page = page_ff;
   assign dg.module_num = module_ff;

   // Learning mode records the legacy master's requests as a listener.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         learnValid_ff <= 1'b0;
         learnAddr_ff <= 8'h00;
      end
      else
      begin
         learnValid_ff <= 1'b0;
         // Master mode may drop in the very cycle a frame arrives; drop it too.
         if (state_ff == ST_LEARN && learnActive && rxValid && rxCrcOk)
         begin
            learnValid_ff <= 1'b1;
            learnAddr_ff <= rxAddr;
         end
      end
   end

   diag_emitter u_emit
   (
      .mclk(mclk),
      .rst(rst),
      .dg(dg.emit),
      .diagValid(diagValid),
      .diagReady(diagReady),
      .diagByte(diagByte),
      .diagLast(diagLast)
   );

   // A new frame only starts from idle, so requests never overlap.
   property p_one_outstanding;
      @(posedge mclk) disable iff (rst)
      txStart |-> $past(state_ff) == ST_IDLE;
   endproperty
   a_one_outstanding: assert property (p_one_outstanding)
      else $error("Request started while another was outstanding.");

   // Broadcasts never enter the reply wait.
   property p_bcast_nowait;
      @(posedge mclk) disable iff (rst)
      (state_ff == ST_SEND && txDone && addr_ff == ADDR_BROADCAST) |=> state_ff == ST_IDLE;
   endproperty
   a_bcast_nowait: assert property (p_bcast_nowait)
      else $error("Broadcast waited for a reply.");

   // Timeout raises the failure pulse one cycle later.
   property p_timeout_fail;
      @(posedge mclk) disable iff (rst)
      timedOut |=> reqFailed && state_ff == ST_IDLE;
   endproperty
   a_timeout_fail: assert property (p_timeout_fail)
      else $error("Timeout did not abandon the request.");

   // Third miss in a row enters diagnostic mode.
   property p_enter_diag;
      @(posedge mclk) disable iff (rst)
      (timedOut && miss_ff == 2'h2) |=> diagMode;
   endproperty
   a_enter_diag: assert property (p_enter_diag)
      else $error("Diagnostic mode not entered after three misses.");

   // Fewer than three misses keep normal operation.
   property p_no_early_diag;
      @(posedge mclk) disable iff (rst)
      (!diagMode && miss_ff < 2'h2) |=> !diagMode;
   endproperty
   a_no_early_diag: assert property (p_no_early_diag)
      else $error("Diagnostic mode entered too early.");

   // A good reply leaves diagnostics and clears the miss count.
   property p_exit_diag;
      @(posedge mclk) disable iff (rst)
      replyMatch |=> !diagMode && miss_ff == 2'h0;
   endproperty
   a_exit_diag: assert property (p_exit_diag)
      else $error("Reply did not clear diagnostics.");

   // Diagnostics start a packet at each period boundary that finds the emitter idle.
   property p_diag_periodic;
      @(posedge mclk) disable iff (rst)
      (diagMode && period_ff == '0 && !dg.busy) |=> diagValid;
   endproperty
   a_diag_periodic: assert property (p_diag_periodic)
      else $error("Diagnose packet not emitted on period.");

   // Learning output only when configured as master.
   property p_learn_master;
      @(posedge mclk) disable iff (rst)
      learnValid |-> $past(masterMode);
   endproperty
   a_learn_master: assert property (p_learn_master)
      else $error("Learning active outside master mode.");

   // Transmitted address is never a reserved one.
   property p_addr_legal;
      @(posedge mclk) disable iff (rst)
      txStart |-> txAddr <= ADDR_UNICAST_MAX;
   endproperty
   a_addr_legal: assert property (p_addr_legal)
      else $error("Reserved address transmitted.");

endmodule : modbus_serial_poll_diag

`default_nettype wire

// ===== testbench/slave_model.sv
`timescale 1ns/10ps
`default_nettype none

// Stand-in for the serial slaves: finishes each frame, then answers it unless it is a broadcast or the slave is silent.
module slave_model
(
   input wire logic mclk,
   input wire logic txStart,
   input wire logic [7:0] txAddr,
   input wire logic [1:0] replyMode,
   input wire logic [4:0] replyDelay,
   input wire logic kick,
   input wire logic [7:0] kickAddr,
   output logic txDone,
   output logic rxValid,
   output logic [7:0] rxAddr,
   output logic rxException,
   output logic rxCrcOk
);
   // Reply mode: 0 silent, 1 normal, 2 exception, 3 corrupted check field.
   logic [7:0] addrSeen;

   // Drives one received frame for a cycle, then shows the inverse.
   // Released lines never keep their old value, so stale data cannot pass.
   task send(input logic [7:0] ad, input logic ex, input logic ok);
      rxValid <= 1'b1;
      rxAddr <= ad;
      rxException <= ex;
      rxCrcOk <= ok;
      @(posedge mclk);
      rxValid <= 1'b0;
      rxAddr <= ~ad;
      rxException <= ~ex;
      rxCrcOk <= ~ok;
   endtask : send

   // Lines start quiet.
   initial
   begin
      txDone = 1'b0;
      rxValid = 1'b0;
      rxAddr = 8'h00;
      rxException = 1'b0;
      rxCrcOk = 1'b0;
   end

   // One frame is served at a time; a slave only speaks when addressed.
   always
   begin
      @(posedge mclk);
      if (txStart === 1'b1)
      begin
         addrSeen = txAddr;
         repeat (2) @(posedge mclk);
         txDone <= 1'b1;
         @(posedge mclk);
         txDone <= 1'b0;
         // A broadcast or a silent slave gets no reply.
         if (addrSeen != 8'h00 && replyMode != 2'h0)
         begin
            repeat (replyDelay) @(posedge mclk);
            send(addrSeen, replyMode == 2'h2, replyMode != 2'h3);
         end
      end
      // A legacy master's request, offered only when the bench asks for one.
      else if (kick === 1'b1)
      begin
         send(kickAddr, 1'b0, 1'b1);
      end
   end
endmodule : slave_model

`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import poll_pkg::*;
   // Short counts keep the run brief; expectations derive from them.
   localparam int TO = 20;
   localparam int DP = 50;
   logic mclk, rst, masterMode, learnEnable, reqValid, reqReady, txStart, txDone, rxValid;
   logic rxException, rxCrcOk, reqFailed, reqOk, exceptionSeen, learnValid, diagMode;
   logic diagValid, diagReady, diagLast, kick;
   logic [7:0] reqAddr, reqPage, reqModule, txAddr, rxAddr, learnAddr, diagByte, kickAddr;
   logic [1:0] replyMode;
   logic [4:0] replyDelay;
   int mismatches, nChecks;

   modbus_serial_poll_diag #(.TIMEOUT_CYCLES(TO), .DIAG_PERIOD_CYCLES(DP))
      i_modbus_serial_poll_diag
   (
      .mclk(mclk), .rst(rst), .masterMode(masterMode), .learnEnable(learnEnable),
      .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr), .reqPage(reqPage),
      .reqModule(reqModule), .txStart(txStart), .txAddr(txAddr), .txDone(txDone),
      .rxValid(rxValid), .rxAddr(rxAddr), .rxException(rxException), .rxCrcOk(rxCrcOk),
      .reqFailed(reqFailed), .reqOk(reqOk), .exceptionSeen(exceptionSeen),
      .learnValid(learnValid), .learnAddr(learnAddr), .diagMode(diagMode),
      .diagValid(diagValid), .diagReady(diagReady), .diagByte(diagByte), .diagLast(diagLast)
   );

   slave_model i_slave_model
   (
      .mclk(mclk), .txStart(txStart), .txAddr(txAddr), .replyMode(replyMode),
      .replyDelay(replyDelay), .kick(kick), .kickAddr(kickAddr), .txDone(txDone),
      .rxValid(rxValid), .rxAddr(rxAddr), .rxException(rxException), .rxCrcOk(rxCrcOk)
   );

   // Counts a comparison and reports it when the values differ.
   task check(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Prints the verdict and ends the run.
   task stop_test;
      if (mismatches == 0 && nChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   // Issues one request and tallies every pulse until the block is idle again.
   task automatic run(input logic [7:0] a, pg, md, input logic [1:0] m,
                      input logic [4:0] d, input logic eTx, eOk, eFail, eExc);
      int nTx = 0, nOk = 0, nFail = 0, nExc = 0, t = 0, ft = 0, post = 0;
      logic busy = 1'b0;
      @(posedge mclk);
      replyMode <= m;
      replyDelay <= d;
      reqValid <= 1'b1;
      reqAddr <= a;
      reqPage <= pg;
      reqModule <= md;
      @(posedge mclk);
      reqValid <= 1'b0;
      // Idle must hold a few cycles so a late result pulse is still caught.
      for (int k = 0; k < 60 && post < 3; k++)
      begin
         @(negedge mclk);
         if (txStart === 1'b1)
         begin
            nTx++;
            check(txAddr, a);
         end
         busy = busy | (reqReady === 1'b0);
         if (busy && reqReady === 1'b1)
            post++;
         t = (txDone === 1'b1) ? 0 : t + 1;
         if (reqFailed === 1'b1)
            ft = t;
         nOk += int'(reqOk === 1'b1);
         nFail += int'(reqFailed === 1'b1);
         nExc += int'(exceptionSeen === 1'b1);
      end
      if (eTx && post < 3)
      begin
         mismatches++;
         stop_test;
      end
      check(busy, eTx);
      check(nTx, eTx);
      check(nOk, eOk);
      check(nFail, eFail);
      check(nExc, eExc);
      if (eFail)
         check(ft >= TO && ft <= TO + 3, 1'b1);
   endtask : run

   // Waits for a diagnose packet and takes its bytes with a stalling receiver.
   // The wait before the packet must fall between lo and hi cycles.
   task automatic packet(input logic [7:0] pg, md, input int lo, hi);
      logic [7:0] exp [3] = '{DIAG_LEN, pg, md};
      int k = 0;
      while (diagValid !== 1'b1 && k < 80)
      begin
         @(negedge mclk);
         k++;
      end
      if (diagValid !== 1'b1)
      begin
         mismatches++;
         stop_test;
      end
      check(k >= lo && k <= hi, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         check(diagValid, 1'b1);
         check(diagByte, exp[i]);
         check(diagLast, i == 2);
         @(posedge mclk);
         diagReady <= 1'b1;
         @(posedge mclk);
         diagReady <= 1'b0;
         @(negedge mclk);
      end
      check(diagValid, 1'b0);
   endtask : packet

   // Plain, slow, boundary, broadcast and reserved requests.
   task t_requests;
      run(8'h05, 8'h00, 8'h01, 2'h1, 5'd3, 1, 1, 0, 0);
      run(8'hf7, 8'h00, 8'h02, 2'h1, 5'd15, 1, 1, 0, 0);
      run(ADDR_BROADCAST, 8'h00, 8'h01, 2'h1, 5'd3, 1, 0, 0, 0);
      run(ADDR_RESERVED_MIN, 8'h00, 8'h01, 2'h1, 5'd3, 0, 0, 0, 0);
   endtask : t_requests

   // Misses are cleared by an exception reply; only three in a row count.
   task t_misses;
      run(8'h07, 8'h00, 8'h01, 2'h0, 5'd3, 1, 0, 1, 0);
      run(8'h07, 8'h00, 8'h01, 2'h0, 5'd3, 1, 0, 1, 0);
      run(8'h07, 8'h00, 8'h01, 2'h2, 5'd3, 1, 1, 0, 1);
      check(diagMode, 1'b0);
      run(8'h07, 8'h00, 8'h01, 2'h3, 5'd3, 1, 0, 1, 0);
      run(8'h07, 8'h00, 8'h01, 2'h0, 5'd3, 1, 0, 1, 0);
      check(diagMode, 1'b0);
      run(8'h09, 8'h01, 8'h03, 2'h0, 5'd3, 1, 0, 1, 0);
      check(diagMode, 1'b1);
   endtask : t_misses

   // Packets repeat while diagnosing; a correct reply ends the mode.
   task t_diag;
      packet(8'h01, 8'h03, 0, 0);
      packet(8'h01, 8'h03, DP - 8, DP - 6);
      run(8'h09, 8'h01, 8'h03, 2'h1, 5'd3, 1, 1, 0, 0);
      check(diagMode, 1'b0);
   endtask : t_diag

   // Listens to a legacy master's request, in master mode and outside it.
   task automatic learn(input logic mm, input logic [7:0] a, input logic exp);
      int n = 0;
      @(posedge mclk);
      masterMode <= mm;
      learnEnable <= 1'b1;
      @(posedge mclk);
      kick <= 1'b1;
      kickAddr <= a;
      @(posedge mclk);
      kick <= 1'b0;
      repeat (8)
      begin
         @(negedge mclk);
         if (learnValid === 1'b1)
         begin
            n++;
            check(learnAddr, a);
         end
      end
      check(reqReady, 1'b0);
      check(n, exp);
      @(posedge mclk);
      learnEnable <= 1'b0;
      masterMode <= 1'b1;
      repeat (2) @(negedge mclk);
      check(reqReady, 1'b1);
   endtask : learn

   task t_learn;
      learn(1'b1, 8'h11, 1'b1);
      learn(1'b0, 8'h22, 1'b0);
   endtask : t_learn

   // Reset in mid-wait drops the request; no late failure may follow it.
   task automatic t_reset;
      int nFail = 0;
      @(posedge mclk);
      replyMode <= 2'h0;
      reqValid <= 1'b1;
      reqAddr <= 8'h0a;
      @(posedge mclk);
      reqValid <= 1'b0;
      repeat (8) @(posedge mclk);
      rst <= 1'b1;
      @(negedge mclk);
      check({txStart, reqFailed, reqOk, diagMode, diagValid, learnValid}, 6'h00);
      check(reqReady, 1'b1);
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (TO + 5)
      begin
         @(negedge mclk);
         nFail += int'(reqFailed === 1'b1);
      end
      check(nFail, 0);
      run(8'h05, 8'h02, 8'h04, 2'h1, 5'd3, 1, 1, 0, 0);
   endtask : t_reset

   // Free-running 25 MHz clock.
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      stop_test;
   end

   // Main sequence: reset for three cycles, then each scenario in turn.
   initial
   begin
      rst = 1'b1;
      masterMode = 1'b1;
      learnEnable = 1'b0;
      reqValid = 1'b0;
      reqAddr = 8'h00;
      reqPage = 8'h00;
      reqModule = 8'h00;
      diagReady = 1'b0;
      kick = 1'b0;
      kickAddr = 8'h00;
      replyMode = 2'h0;
      replyDelay = 5'd0;
      mismatches = 0;
      nChecks = 0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_requests;
      t_misses;
      t_diag;
      t_learn;
      t_reset;
      stop_test;
   end
endmodule : testbench

`default_nettype wire
